/* File: src/cfs_defines.vh */
// Constants for the converter fault supervisor.
// Assumes a 20 MHz clock and comparator flags already qualified by the analog front end.
// Functional notes
// - Current limiting is left running during overload; a shutdown happens only when the output falls below 4.0 V.
// - In auto-restart mode an overcurrent shutdown is retried for ever, shutting down again while the fault remains.
// - Overcurrent warn and fault thresholds and the response are settable; latch-off clears only by power cycle or a 1 ms on/off toggle.
// - Output overvoltage above the set limit shuts the output down, with endless auto-restart by default.
// - Overvoltage threshold and response are settable; the latch clears by power cycle or a 1 ms on/off toggle.
// - Overtemperature shuts down before parts exceed ratings and by default restarts after cooling about 13 degrees C.
// - An overtemperature warning is raised above a derated threshold that lies below the shutdown threshold.
// - Temperature warn and fault thresholds and response are settable; a latched shutdown clears by power cycle or 1 ms toggle.
// - The output is enabled once input exceeds the turn-on level and disabled once it falls below the turn-off level.
// - Input above the overvoltage limit shuts down; by default restart follows once input falls 7 V below that limit.
// - On/off polarity is positive (run while high) or negative (run while low, the default).
// - Input overvoltage limit defaults to 85 V, and restart follows that setting minus 7 V.
`ifndef CFS_DEFINES_VH
`define CFS_DEFINES_VH
`define CFS_CLK_HZ 20000000
`define CFS_TOGGLE_US 1000
`define CFS_TOGGLE_CYC ((`CFS_CLK_HZ / 1000000) * `CFS_TOGGLE_US)
`define CFS_RESTART_US 100
`define CFS_RESTART_CYC ((`CFS_CLK_HZ / 1000000) * `CFS_RESTART_US)
`define CFS_UV_TRIP_MV 16'd4000
`define CFS_VIN_ON_MV 16'd35000
`define CFS_VIN_OFF_MV 16'd33000
// Wider than the 16-bit threshold ports; the host scales it to fit
`define CFS_VIN_OV_MV 17'd85000
`define CFS_VIN_OV_HYS_MV 16'd7000
`define CFS_OT_HYS_C 16'd13
`define CFS_RESP_LATCH 1'b1
`define CFS_RESP_RESTART 1'b0
`endif

/* File: src/cfs_supervisor.v */
// Converter fault supervisor: decides when the output stage may run.
// Assumes measured values arrive in mV / mA / degrees C from on-chip logic (same clock);
// the on/off pin is asynchronous and synchronised here.
`include "cfs_defines.vh"
`timescale 1ns/1ps
module cfs_supervisor #(
   parameter MW = 16,
   parameter TOGGLE_CYC = `CFS_TOGGLE_CYC,
   parameter RESTART_CYC = `CFS_RESTART_CYC
) (
   input wire mclk_i,
   input wire rst_n_i,
   input wire onoff_pin_i,
   input wire onoff_neg_pol_i,
   input wire [MW-1:0] vout_mv_i,
   input wire [MW-1:0] iout_ma_i,
   input wire [MW-1:0] vin_mv_i,
   input wire [MW-1:0] temp_c_i,
   input wire ilim_active_i,
   input wire [MW-1:0] oc_warn_ma_i,
   input wire [MW-1:0] oc_fault_ma_i,
   input wire oc_resp_latch_i,
   input wire [MW-1:0] ov_fault_mv_i,
   input wire ov_resp_latch_i,
   input wire [MW-1:0] ot_warn_c_i,
   input wire [MW-1:0] ot_fault_c_i,
   input wire ot_resp_latch_i,
   input wire [MW-1:0] vin_on_mv_i,
   input wire [MW-1:0] vin_off_mv_i,
   input wire [MW-1:0] vin_ov_mv_i,
   output reg stage_en_o,
   output reg oc_warn_o,
   output reg ot_warn_o,
   output reg oc_fault_o,
   output reg ov_fault_o,
   output reg ot_fault_o,
   output reg uv_lock_o,
   output reg vin_ov_lock_o,
   output reg latched_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers
   function ge;
      input [MW-1:0] a;
      input [MW-1:0] b;
      begin
         ge = (a >= b);
      end
   endfunction

   function [MW-1:0] sub_sat;
      input [MW-1:0] a;
      input [MW-1:0] b;
      begin
         sub_sat = (a > b) ? (a - b) : {MW{1'b0}};
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // On/off pin
   wire onoff_s;
   cfs_sync #(.W(1)) u_sync (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .d_i(onoff_pin_i),
      .q_o(onoff_s)
   );

   // Synchroniser reset value is not the idle level of the pin for every
   // polarity, so no run request is believed until it has filled
   reg [1:0] warm_reg;
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         warm_reg <= 2'b00;
      end else begin
         warm_reg <= {warm_reg[0], 1'b1};
      end
   end

   // Negative polarity runs on a low pin, positive on a high one
   wire run_req = (onoff_neg_pol_i ? ~onoff_s : onoff_s) & warm_reg[1];

   // Off request held 1 ms clears latches; shorter glitches do not
   wire clr_done;
   cfs_timer #(.CYC(TOGGLE_CYC), .W(16)) u_tog (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .run_i(~run_req),
      .done_o(clr_done)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Fault detection
   // Current limit alone never trips; only collapse of vout under limiting or at the fault current
   wire oc_trip = (ilim_active_i | ge(iout_ma_i, oc_fault_ma_i)) &
                  ~ge(vout_mv_i, `CFS_UV_TRIP_MV) & stage_en_o;
   wire ov_trip = ~ge(ov_fault_mv_i, vout_mv_i);
   wire ot_trip = ge(temp_c_i, ot_fault_c_i);
   wire ot_cool = ~ge(temp_c_i, sub_sat(ot_fault_c_i, `CFS_OT_HYS_C));
   wire vin_ov_rel = ~ge(vin_mv_i, sub_sat(vin_ov_mv_i, `CFS_VIN_OV_HYS_MV));

   ////////////////////////////////////////////////////////////////////////////////
   // Lockouts with hysteresis
   reg uv_next;
   reg vin_ov_next;
   always @* begin
      uv_next = uv_lock_o;
      if (ge(vin_mv_i, vin_on_mv_i) && vin_mv_i != vin_on_mv_i)
         uv_next = 1'b0;
      else if (!ge(vin_mv_i, vin_off_mv_i))
         uv_next = 1'b1;
      // Overlapping thresholds from the host resolve to unlocked here; the turn-on test wins
      vin_ov_next = vin_ov_lock_o;
      if (!ge(vin_ov_mv_i, vin_mv_i))
         vin_ov_next = 1'b1;
      else if (vin_ov_rel)
         vin_ov_next = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Fault state: hiccup timer for OC/OV auto-restart, cooling hysteresis for OT, latch for latch-off
   reg oc_latch_reg;
   reg ov_latch_reg;
   reg ot_latch_reg;
   reg hiccup_reg;
   wire hiccup_done;
   cfs_timer #(.CYC(RESTART_CYC), .W(16)) u_hic (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .run_i(hiccup_reg),
      .done_o(hiccup_done)
   );

   reg oc_latch_next;
   reg ov_latch_next;
   reg ot_latch_next;
   reg hiccup_next;
   reg ot_fault_next;
   always @* begin
      oc_latch_next = oc_latch_reg;
      ov_latch_next = ov_latch_reg;
      ot_latch_next = ot_latch_reg;
      hiccup_next = hiccup_reg;
      ot_fault_next = ot_fault_o;
      // Clears first; a new trip in the same cycle wins
      if (clr_done) begin
         oc_latch_next = 1'b0;
         ov_latch_next = 1'b0;
         ot_latch_next = 1'b0;
      end
      if (hiccup_done)
         hiccup_next = 1'b0;
      if (oc_trip) begin
         if (oc_resp_latch_i == `CFS_RESP_LATCH)
            oc_latch_next = 1'b1;
         else
            hiccup_next = 1'b1;
      end
      if (ov_trip) begin
         if (ov_resp_latch_i == `CFS_RESP_LATCH)
            ov_latch_next = 1'b1;
         else
            hiccup_next = 1'b1;
      end
      if (ot_trip) begin
         ot_fault_next = 1'b1;
         if (ot_resp_latch_i == `CFS_RESP_LATCH)
            ot_latch_next = 1'b1;
      end else if (ot_cool) begin
         ot_fault_next = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registers and outputs
   wire any_latch = oc_latch_next | ov_latch_next | ot_latch_next;
   wire stage_next = run_req & ~uv_next & ~vin_ov_next & ~any_latch &
                     ~hiccup_next & ~ot_fault_next & ~ov_trip;

   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         uv_lock_o <= 1'b1;
         vin_ov_lock_o <= 1'b0;
         oc_latch_reg <= 1'b0;
         ov_latch_reg <= 1'b0;
         ot_latch_reg <= 1'b0;
         hiccup_reg <= 1'b0;
         ot_fault_o <= 1'b0;
         stage_en_o <= 1'b0;
         oc_warn_o <= 1'b0;
         ot_warn_o <= 1'b0;
         oc_fault_o <= 1'b0;
         ov_fault_o <= 1'b0;
         latched_o <= 1'b0;
      end else begin
         uv_lock_o <= uv_next;
         vin_ov_lock_o <= vin_ov_next;
         oc_latch_reg <= oc_latch_next;
         ov_latch_reg <= ov_latch_next;
         ot_latch_reg <= ot_latch_next;
         hiccup_reg <= hiccup_next;
         ot_fault_o <= ot_fault_next;
         stage_en_o <= stage_next;
         oc_warn_o <= ge(iout_ma_i, oc_warn_ma_i);
         ot_warn_o <= ge(temp_c_i, ot_warn_c_i);
         oc_fault_o <= oc_trip | oc_latch_next;
         ov_fault_o <= ov_trip | ov_latch_next;
         latched_o <= any_latch;
      end
   end
endmodule

/* File: src/cfs_sync.v */
// Two flip-flop synchroniser for asynchronous pin levels.
// Assumes the input is a level, not a short pulse.
`timescale 1ns/1ps
module cfs_sync #(
   parameter W = 1
) (
   input wire mclk_i,
   input wire rst_n_i,
   input wire [W-1:0] d_i,
   output reg [W-1:0] q_o
);
   reg [W-1:0] meta_reg;
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_reg <= {W{1'b0}};
         q_o <= {W{1'b0}};
      end else begin
         meta_reg <= d_i;
         q_o <= meta_reg;
      end
   end
endmodule

/* File: src/cfs_timer.v */
// Retriggerable cycle counter: done is high once run has held for CYC cycles.
// Assumes run is synchronous to mclk_i.
`timescale 1ns/1ps
module cfs_timer #(
   parameter CYC = 20000,
   parameter W = 16
) (
   input wire mclk_i,
   input wire rst_n_i,
   input wire run_i,
   output reg done_o
);
   localparam integer LAST_I = CYC - 1;
   localparam [W-1:0] LAST = LAST_I[W-1:0];
   reg [W-1:0] cnt_reg;
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_reg <= {W{1'b0}};
         done_o <= 1'b0;
      end else if (!run_i) begin
         cnt_reg <= {W{1'b0}};
         done_o <= 1'b0;
      end else if (cnt_reg == LAST) begin
         done_o <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
      end
   end
endmodule

/* File: testbench/cfs_host_model.sv */
// Host side: on/off pin and turn-on threshold.
// Assumes the pin input sees an open pin as high.
`timescale 1ns/1ps
module cfs_host_model (
   input wire run_i,
   input wire used_i,
   input wire neg_pol_i,
   input wire [15:0] off_mv_i,
   output wire pin_o,
   output wire [15:0] on_mv_o
);
   // Unused pin: shorted low for negative logic, open for positive
   assign pin_o = used_i ? (neg_pol_i ^ run_i) : !neg_pol_i;
   // Smallest legal hysteresis, the harshest case for the device
   assign on_mv_o = off_mv_i + 16'd2000;
endmodule

/* File: testbench/cfs_supervisor_chk.sv */
// Port checker for the supervisor.
// Bound to every cfs_supervisor instance.
`timescale 1ns/1ps
module cfs_supervisor_chk (
   input wire mclk_i,
   input wire rst_n_i,
   input wire onoff_pin_i,
   input wire onoff_neg_pol_i,
   input wire [15:0] vout_mv_i,
   input wire [15:0] iout_ma_i,
   input wire [15:0] vin_mv_i,
   input wire [15:0] temp_c_i,
   input wire ilim_active_i,
   input wire [15:0] oc_fault_ma_i,
   input wire [15:0] ov_fault_mv_i,
   input wire [15:0] ot_warn_c_i,
   input wire [15:0] ot_fault_c_i,
   input wire [15:0] vin_off_mv_i,
   input wire [15:0] vin_ov_mv_i,
   input wire stage_en_o,
   input wire ot_warn_o,
   input wire oc_fault_o,
   input wire ov_fault_o,
   input wire ot_fault_o,
   input wire uv_lock_o,
   input wire vin_ov_lock_o,
   input wire latched_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   wire run_req = onoff_neg_pol_i ? !onoff_pin_i : onoff_pin_i;
   wire hot = temp_c_i >= ot_warn_c_i;
   wire oc_hit = ilim_active_i || iout_ma_i >= oc_fault_ma_i;
   ////////////////////////////////////////////////////////////////////////
   // Eight cycles covers the pin sync and toggle timer lag
   sequence s_run8; run_req [*8]; endsequence
   property p_latch; s_run8 ##0 latched_o |=> latched_o; endproperty
   a_latch: assert property (p_latch) else $error("latch cleared without toggle");
   property p_safe; stage_en_o |-> !(uv_lock_o | vin_ov_lock_o | latched_o | ot_fault_o); endproperty
   a_safe: assert property (p_safe) else $error("stage on while blocked");
   property p_uv; vin_mv_i < vin_off_mv_i |=> uv_lock_o && !stage_en_o; endproperty
   a_uv: assert property (p_uv) else $error("low input not locked out");
   property p_vinov; vin_mv_i > vin_ov_mv_i |=> vin_ov_lock_o && !stage_en_o; endproperty
   a_vinov: assert property (p_vinov) else $error("input overvoltage missed");
   property p_ov; vout_mv_i > ov_fault_mv_i |=> ov_fault_o && !stage_en_o; endproperty
   a_ov: assert property (p_ov) else $error("output overvoltage missed");
   property p_oc; stage_en_o && oc_hit && vout_mv_i < 16'd4000 |=> oc_fault_o && !stage_en_o;
   endproperty
   a_oc: assert property (p_oc) else $error("overload shutdown missed");
   property p_ot; temp_c_i >= ot_fault_c_i |=> ot_fault_o && !stage_en_o; endproperty
   a_ot: assert property (p_ot) else $error("overtemperature missed");
   property p_otw; ##1 ot_warn_o == $past(hot); endproperty
   a_otw: assert property (p_otw) else $error("temperature warning wrong");
endmodule
bind cfs_supervisor cfs_supervisor_chk i_chk (.*);

/* File: testbench/cfs_supervisor_test.sv */
// Self-checking bench for the supervisor.
// Short toggle and hiccup counts keep the run brief.
`timescale 1ns/1ps
module cfs_supervisor_test;
   localparam TOG = 20;
   localparam [16*7-1:0] VT = {16'd52999, 16'd53000, 16'd60001, 16'd35001, 16'd35000,
      16'd32999, 16'd33000};
   localparam [6:0] ET = 7'b1001001;
   localparam [6:0] UT = 7'b0000110;
   reg mclk_i = 0;
   reg rst_n_i = 0;
   reg run = 1, used = 1, neg = 1, ilim = 0, ocl = 0, ovl = 0, otl = 0;
   reg [15:0] vout = 16'd12000, iout = 16'd10000, vin = 16'd48000, temp = 16'd50;
   reg [15:0] voff = 16'd33000, ovlim = 16'd14000, ocwarn = 16'd40000;
   wire pin, en, ocw, otw, ocf, ovf, otf, uvl, vol, lat;
   wire [15:0] von;
   integer errors = 0, compares = 0, cyc = 0, seed = 32'h4510, i, k, n;
   always #25 mclk_i = ~mclk_i;
   cfs_host_model i_host (.run_i(run), .used_i(used), .neg_pol_i(neg), .off_mv_i(voff),
      .pin_o(pin), .on_mv_o(von));
   cfs_supervisor #(.TOGGLE_CYC(TOG), .RESTART_CYC(10)) i_dut (.mclk_i(mclk_i),
      .rst_n_i(rst_n_i), .onoff_pin_i(pin), .onoff_neg_pol_i(neg), .vout_mv_i(vout),
      .iout_ma_i(iout), .vin_mv_i(vin), .temp_c_i(temp), .ilim_active_i(ilim),
      .oc_warn_ma_i(ocwarn), .oc_fault_ma_i(16'd50000), .oc_resp_latch_i(ocl),
      .ov_fault_mv_i(ovlim), .ov_resp_latch_i(ovl), .ot_warn_c_i(16'd100),
      .ot_fault_c_i(16'd120), .ot_resp_latch_i(otl), .vin_on_mv_i(von), .vin_off_mv_i(voff),
      .vin_ov_mv_i(16'd60000), .stage_en_o(en), .oc_warn_o(ocw), .ot_warn_o(otw),
      .oc_fault_o(ocf), .ov_fault_o(ovf), .ot_fault_o(otf), .uv_lock_o(uvl),
      .vin_ov_lock_o(vol), .latched_o(lat));
   ////////////////////////////////////////////////////////////////////////
   function over(input [15:0] a, input [15:0] b);
      over = a > b;
   endfunction
   task step(input integer c);
      repeat (c) @(posedge mclk_i);
      #5;
   endtask
   task chk(input [63:0] nm, input e, input g);
      compares = compares + 1;
      if (g !== e) begin
         errors = errors + 1;
         $display("mismatch %0s exp %b got %b", nm, e, g);
      end
   endtask
   task stop_test;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   always @(posedge mclk_i) begin
      cyc = cyc + 1;
      if (cyc == 3000) begin
         errors = errors + 1;
         stop_test;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      step(20);
      rst_n_i = 1;
      step(6);
      chk("en", 1, en);
      for (k = 0; k < 4; k = k + 1) begin
         neg = k[0];
         used = !k[1];
         run = 0;
         step(6);
         chk("en", !used, en);
         run = 1;
         step(6);
         chk("en", 1, en);
      end
      used = 1;
      for (i = 0; i < 7; i = i + 1) begin
         vin = VT[16*i +: 16];
         step(3);
         chk("en", ET[i], en);
         chk("uvl", UT[i], uvl);
         chk("vol", !ET[i] && !UT[i], vol);
      end
      ilim = 1;
      vout = 16'd4000;
      step(6);
      chk("en", 1, en);
      vout = 16'd3999;
      step(1);
      chk("ocf", 1, ocf);
      n = 0;
      repeat (60) begin
         step(1);
         n = n + en;
      end
      chk("retry", 1, n >= 3);
      ilim = 0;
      vout = 16'd12000;
      step(20);
      chk("en", 1, en);
      for (k = 0; k < 3; k = k + 1) begin
         {otl, ovl, ocl} = 3'b001 << k;
         ilim = k == 0;
         vout = k == 0 ? 16'd3999 : k == 1 ? 16'd15000 : 16'd12000;
         temp = k == 2 ? 16'd120 : 16'd50;
         step(3);
         ilim = 0;
         vout = 16'd12000;
         temp = 16'd50;
         step(30);
         chk("lat", 1, lat);
         // Short toggle must be refused, long one clears
         for (n = 10; n < 40; n = n + 25) begin
            run = 0;
            step(n);
            run = 1;
            step(10);
            chk("en", n > TOG, en);
         end
      end
      {otl, ovl, ocl} = 3'b000;
      temp = 16'd120;
      step(3);
      chk("otf", 1, otf);
      temp = 16'd107;
      step(3);
      chk("otf", 1, otf);
      temp = 16'd106;
      step(3);
      chk("en", 1, en);
      iout = 16'd40000;
      step(2);
      chk("ocw", 1, ocw);
      for (i = 0; i < 200; i = i + 1) begin
         vout = 16'd11000 + {$random(seed)} % 4000;
         temp = {$random(seed)} % 110;
         iout = {$random(seed)} % 45000;
         ovlim = 16'd13000 + {$random(seed)} % 2000;
         voff = 16'd30000 + {$random(seed)} % 3000;
         ocwarn = 16'd30000 + {$random(seed)} % 20000;
         step(1);
         chk("ocw", iout >= ocwarn, ocw);
         chk("ovf", over(vout, ovlim), ovf);
         chk("otw", temp >= 16'd100, otw);
      end
      stop_test;
   end
endmodule
